// file: logic/dts_defs.vh
`ifndef DTS_DEFS_VH
`define DTS_DEFS_VH

// register byte offsets
`define DTS_REG_CTRL 8'h00
`define DTS_REG_TIMER 8'h04
`define DTS_REG_PRE 8'h08
`define DTS_REG_COUNT 8'h0C
`define DTS_REG_DELAY 8'h10
`define DTS_REG_CMD 8'h14
`define DTS_REG_STATUS 8'h18
`define DTS_REG_STORED 8'h1C
`define DTS_REG_FUNC 8'h20

// control fields
`define DTS_CTRL_SRC_LSB 0
`define DTS_CTRL_SRC_MSB 1
`define DTS_CTRL_POL_BIT 2
`define DTS_SRC_IMM 2'h0
`define DTS_SRC_MANUAL 2'h1
`define DTS_SRC_EXT 2'h2
`define DTS_CMD_START_BIT 0
`define DTS_CMD_ABORT_BIT 1

// limits
`define DTS_PRE_MAX 32'h000F423F
`define DTS_COUNT_MIN 32'h00000001
`define DTS_COUNT_MAX 32'h03000000
`define DTS_COUNT_PRE_MAX 32'h000F4240

// reset values
`define DTS_CTRL_RST 3'h0
`define DTS_TIMER_RST 32'h00000014
`define DTS_PRE_RST 32'h00000000
`define DTS_COUNT_RST 32'h00000001
`define DTS_DELAY_RST 32'h00000000
`define DTS_FUNC_RST 4'h0

// timing: sample timer and delay are programmed in microseconds
`define DTS_CLK_PERIOD_PS 25000
`define DTS_US_PS 1000000
`define DTS_CYC_PER_US (`DTS_US_PS / `DTS_CLK_PERIOD_PS)
`define DTS_TIMER_MIN_US 32'h00000014
`define DTS_TIMER_MAX_US 32'hD693A400

`endif

// file: logic/dts_fifo.v
`timescale 1ns/1ps
module dts_fifo #(
    parameter W = 24,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_in,
    input wire rstn_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] rp_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;

    assign in_ready_out = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_out = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_out = mem[rp_reg];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always @(posedge clk_in) begin
        if (push) begin
            mem[wp_reg] <= in_data_in;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp_reg <= {AW{1'b0}};
            rp_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

// file: logic/dts_tick.v
`timescale 1ns/1ps
`include "dts_defs.vh"
module dts_tick #(
    parameter CYC_PER_US = `DTS_CYC_PER_US
) (
    input wire clk_in,
    input wire rstn_in,
    input wire run_in,
    input wire [31:0] period_us_in,
    output wire tick_out
);
    localparam integer CYC_LAST_I = CYC_PER_US - 1;
    localparam [15:0] CYC_LAST = CYC_LAST_I[15:0];
    reg [15:0] pre_reg;
    reg [31:0] us_reg;
    wire us_end;
    wire [31:0] last_us;

    // a zero period behaves as one microsecond rather than never firing
    assign last_us = (period_us_in == 32'h00000000) ? 32'h00000000 : period_us_in - 32'h00000001;
    assign us_end = (pre_reg == CYC_LAST);
    assign tick_out = run_in && us_end && (us_reg >= last_us);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pre_reg <= 16'h0000;
            us_reg <= 32'h00000000;
        end else if (!run_in) begin
            pre_reg <= 16'h0000;
            us_reg <= 32'h00000000;
        end else if (us_end) begin
            pre_reg <= 16'h0000;
            us_reg <= tick_out ? 32'h00000000 : us_reg + 32'h00000001;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end
endmodule

// file: logic/dts_seq.v
// What this block does
// - immediate source triggers at the start command
// - manual: first start arms, second triggers
// - external edge triggers, polarity selectable
// - pre-trigger count accepted from 0 to 999999
// - nonzero pre-trigger samples held while waiting
// - trigger moves held samples, then records rest
// - early trigger completes with fewer pre samples
// - pre-trigger at most count minus one
// - sample spacing programmable 20 us to 3600 s
// - total count 1 to 50331648 samples
// - nonzero pre-trigger limits count to 1000000
// - programmable delay between trigger and digitizing
// - no delay with immediate source or pre-trigger
// - interval and count kept across function change
`timescale 1ns/1ps
`include "dts_defs.vh"
module dts_seq #(
    parameter DW = 24,
    parameter HOLD_AW = 20,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clk_in,
    input wire rstn_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire start_key_in,
    input wire ext_trig_in,
    input wire [DW-1:0] adc_data_in,
    output reg sample_strobe_out,
    output reg [DW-1:0] mem_data_out,
    output reg mem_valid_out,
    input wire mem_ready_in,
    output reg busy_out
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ARMED = 6'h02;
    localparam [5:0] ST_WAIT = 6'h04;
    localparam [5:0] ST_DELAY = 6'h08;
    localparam [5:0] ST_RUN = 6'h10;
    localparam [5:0] ST_FLUSH = 6'h20;
    localparam [HOLD_AW:0] HOLD_DEPTH = {1'b1, {HOLD_AW{1'b0}}};

    reg [2:0] ctrl_reg;
    reg [31:0] timer_reg;
    reg [31:0] pre_reg;
    reg [31:0] count_reg;
    reg [31:0] delay_reg;
    reg [3:0] func_reg;
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg ext_prev_reg;
    reg done_reg;
    reg overrun_reg;
    reg [31:0] pre_goal_reg;
    reg [31:0] post_goal_reg;
    reg [31:0] post_taken_reg;
    reg [31:0] total_goal_reg;
    reg [31:0] stored_reg;
    reg [DW-1:0] hold_mem [0:(1<<HOLD_AW)-1];
    reg [HOLD_AW-1:0] hold_wp_reg;
    reg [HOLD_AW-1:0] hold_rp_reg;
    reg [HOLD_AW:0] hold_cnt_reg;
    reg [31:0] rd_mux;

    wire [1:0] src;
    wire falling;
    wire cmd_wr;
    wire start_ev;
    wire abort_ev;
    wire ext_edge;
    wire trig_ev;
    wire [31:0] cnt_m1;
    wire [31:0] pre_lim;
    wire [31:0] eff_pre;
    wire [31:0] eff_cnt;
    wire delay_en;
    wire sample_run;
    wire sample_tick;
    wire delay_tick;
    wire take;
    wire [31:0] held_wide;
    wire hold_full;
    wire wait_full;
    wire drain_ok;
    wire fifo_in_ready;
    wire fifo_push;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [DW-1:0] fifo_out_data;
    wire hold_wr;
    wire hold_drop_oldest;

    assign src = ctrl_reg[`DTS_CTRL_SRC_MSB:`DTS_CTRL_SRC_LSB];
    assign falling = ctrl_reg[`DTS_CTRL_POL_BIT];
    assign cmd_wr = wr_in && (addr_in == `DTS_REG_CMD);
    assign start_ev = (cmd_wr && wdata_in[`DTS_CMD_START_BIT]) || start_key_in;
    assign abort_ev = cmd_wr && wdata_in[`DTS_CMD_ABORT_BIT];

    // edge of the external line with the chosen polarity
    assign ext_edge = falling ? (ext_prev_reg && !ext_trig_in) : (!ext_prev_reg && ext_trig_in);
    assign trig_ev = (state_reg == ST_WAIT) && ext_edge;

    // effective settings, derived so stored values survive any reorder of writes
    assign cnt_m1 = count_reg - 32'h00000001;
    assign pre_lim = (pre_reg > cnt_m1) ? cnt_m1 : pre_reg;
    assign eff_pre = (src == `DTS_SRC_EXT) ? pre_lim : 32'h00000000;
    assign eff_cnt = ((eff_pre != 32'h00000000) && (count_reg > `DTS_COUNT_PRE_MAX)) ?
        `DTS_COUNT_PRE_MAX : count_reg;
    assign delay_en = (delay_reg != 32'h00000000) && (src != `DTS_SRC_IMM) &&
        (eff_pre == 32'h00000000);

    assign held_wide = {{(31-HOLD_AW){1'b0}}, hold_cnt_reg};
    assign hold_full = (hold_cnt_reg == HOLD_DEPTH);
    assign wait_full = (held_wide >= pre_goal_reg) || hold_full;

    assign sample_run = ((state_reg == ST_WAIT) && (pre_goal_reg != 32'h00000000)) ||
        ((state_reg == ST_RUN) && (post_taken_reg != post_goal_reg));

    dts_tick #(
        .CYC_PER_US(`DTS_CYC_PER_US)
    ) u_sample_tick (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(sample_run),
        .period_us_in(timer_reg),
        .tick_out(sample_tick)
    );

    dts_tick #(
        .CYC_PER_US(`DTS_CYC_PER_US)
    ) u_delay_tick (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(state_reg == ST_DELAY),
        .period_us_in(delay_reg),
        .tick_out(delay_tick)
    );

    // a tick that lands on the trigger cycle is dropped so the held count is exact
    assign take = sample_tick && !trig_ev && !abort_ev;
    assign hold_drop_oldest = take && (state_reg == ST_WAIT) && wait_full;
    assign hold_wr = take && ((state_reg == ST_WAIT) || !hold_full);
    assign drain_ok = (state_reg == ST_RUN) || (state_reg == ST_FLUSH);
    assign fifo_push = drain_ok && (hold_cnt_reg != {(HOLD_AW+1){1'b0}}) && fifo_in_ready;

    always @(posedge clk_in) begin
        if (hold_wr) begin
            hold_mem[hold_wp_reg] <= adc_data_in;
        end
    end

    dts_fifo #(
        .W(DW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(hold_mem[hold_rp_reg]),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );

    assign fifo_out_ready = !mem_valid_out || mem_ready_in;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_ev) begin
                    if (src == `DTS_SRC_MANUAL) begin
                        state_next = ST_ARMED;
                    end else if (src == `DTS_SRC_EXT) begin
                        state_next = ST_WAIT;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_ARMED: begin
                if (start_ev) begin
                    state_next = delay_en ? ST_DELAY : ST_RUN;
                end
            end
            ST_WAIT: begin
                if (trig_ev) begin
                    state_next = delay_en ? ST_DELAY : ST_RUN;
                end
            end
            ST_DELAY: begin
                if (delay_tick) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (post_taken_reg == post_goal_reg) begin
                    state_next = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (stored_reg == total_goal_reg) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (abort_ev) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_IDLE;
            ext_prev_reg <= 1'b0;
            done_reg <= 1'b0;
            overrun_reg <= 1'b0;
            pre_goal_reg <= 32'h00000000;
            post_goal_reg <= 32'h00000000;
            post_taken_reg <= 32'h00000000;
            total_goal_reg <= 32'h00000000;
            stored_reg <= 32'h00000000;
            hold_wp_reg <= {HOLD_AW{1'b0}};
            hold_rp_reg <= {HOLD_AW{1'b0}};
            hold_cnt_reg <= {(HOLD_AW+1){1'b0}};
        end else begin
            state_reg <= state_next;
            ext_prev_reg <= ext_trig_in;
            if (state_reg == ST_IDLE && start_ev) begin
                // pre and post sample counts are frozen here; timer, delay and trigger polarity are still read live
                pre_goal_reg <= eff_pre;
                post_goal_reg <= eff_cnt - eff_pre;
                total_goal_reg <= eff_cnt - eff_pre;
                post_taken_reg <= 32'h00000000;
                stored_reg <= 32'h00000000;
                done_reg <= 1'b0;
                overrun_reg <= 1'b0;
                hold_wp_reg <= {HOLD_AW{1'b0}};
                hold_rp_reg <= {HOLD_AW{1'b0}};
                hold_cnt_reg <= {(HOLD_AW+1){1'b0}};
            end else begin
                if (trig_ev) begin
                    total_goal_reg <= post_goal_reg + held_wide;
                end
                if (state_reg == ST_FLUSH && state_next == ST_IDLE) begin
                    done_reg <= 1'b1;
                end
                if (take && state_reg == ST_RUN) begin
                    post_taken_reg <= post_taken_reg + 32'h00000001;
                    if (hold_full && !fifo_push) begin
                        overrun_reg <= 1'b1;
                    end
                end
                if (hold_wr) begin
                    hold_wp_reg <= hold_wp_reg + 1'b1;
                end
                if (hold_drop_oldest || fifo_push) begin
                    hold_rp_reg <= hold_rp_reg + 1'b1;
                end
                if (hold_wr && !hold_drop_oldest && !fifo_push) begin
                    hold_cnt_reg <= hold_cnt_reg + 1'b1;
                end else if (fifo_push && !hold_wr) begin
                    hold_cnt_reg <= hold_cnt_reg - 1'b1;
                end
                if (fifo_push) begin
                    stored_reg <= stored_reg + 32'h00000001;
                end
                if (abort_ev) begin
                    hold_cnt_reg <= {(HOLD_AW+1){1'b0}};
                    hold_rp_reg <= hold_wp_reg;
                end
            end
        end
    end

    // settings registers; writing the function code leaves timer and count alone
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_reg <= `DTS_CTRL_RST;
            timer_reg <= `DTS_TIMER_RST;
            pre_reg <= `DTS_PRE_RST;
            count_reg <= `DTS_COUNT_RST;
            delay_reg <= `DTS_DELAY_RST;
            func_reg <= `DTS_FUNC_RST;
        end else if (wr_in) begin
            case (addr_in)
                `DTS_REG_CTRL: begin
                    ctrl_reg <= wdata_in[2:0];
                end
                `DTS_REG_TIMER: begin
                    if (wdata_in < `DTS_TIMER_MIN_US) begin
                        timer_reg <= `DTS_TIMER_MIN_US;
                    end else if (wdata_in > `DTS_TIMER_MAX_US) begin
                        timer_reg <= `DTS_TIMER_MAX_US;
                    end else begin
                        timer_reg <= wdata_in;
                    end
                end
                `DTS_REG_PRE: begin
                    pre_reg <= (wdata_in > `DTS_PRE_MAX) ? `DTS_PRE_MAX : wdata_in;
                end
                `DTS_REG_COUNT: begin
                    if (wdata_in < `DTS_COUNT_MIN) begin
                        count_reg <= `DTS_COUNT_MIN;
                    end else if (wdata_in > `DTS_COUNT_MAX) begin
                        count_reg <= `DTS_COUNT_MAX;
                    end else begin
                        count_reg <= wdata_in;
                    end
                end
                `DTS_REG_DELAY: begin
                    delay_reg <= wdata_in;
                end
                `DTS_REG_FUNC: begin
                    func_reg <= wdata_in[3:0];
                end
                default: begin
                    func_reg <= func_reg;
                end
            endcase
        end
    end

    always @* begin
        case (addr_in)
            `DTS_REG_CTRL: rd_mux = {29'h00000000, ctrl_reg};
            `DTS_REG_TIMER: rd_mux = timer_reg;
            `DTS_REG_PRE: rd_mux = eff_pre;
            `DTS_REG_COUNT: rd_mux = eff_cnt;
            `DTS_REG_DELAY: rd_mux = delay_en ? delay_reg : 32'h00000000;
            `DTS_REG_STATUS: rd_mux = {22'h000000, delay_en, overrun_reg, done_reg,
                (state_reg != ST_IDLE), state_reg};
            `DTS_REG_STORED: rd_mux = stored_reg;
            `DTS_REG_FUNC: rd_mux = {28'h0000000, func_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 32'h00000000;
            sample_strobe_out <= 1'b0;
            mem_data_out <= {DW{1'b0}};
            mem_valid_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rd_mux : 32'h00000000;
            sample_strobe_out <= hold_wr;
            busy_out <= (state_next != ST_IDLE);
            if (fifo_out_ready) begin
                mem_valid_out <= fifo_out_valid;
                mem_data_out <= fifo_out_data;
            end
        end
    end
endmodule

// file: tb/dts_seq_chk.sv
`timescale 1ns/1ps
`include "dts_defs.vh"
module dts_seq_chk #(
    parameter DW = 24
) (
    input wire clk_in,
    input wire rstn_in,
    input wire [7:0] addr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire start_key_in,
    input wire sample_strobe_out,
    input wire [DW-1:0] mem_data_out,
    input wire mem_valid_out,
    input wire mem_ready_in,
    input wire busy_out
);
    reg rd_q;
    reg [7:0] addr_q;
    reg [9:0] gap;
    reg seen;
    // gap saturates so long idle spells never wrap into a false short spacing
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_q <= 1'b0;
            addr_q <= 8'h00;
            gap <= 10'h000;
            seen <= 1'b0;
        end else begin
            rd_q <= rd_in;
            addr_q <= addr_in;
            if (sample_strobe_out) begin
                gap <= 10'h000;
                seen <= 1'b1;
            end else if (gap != 10'h3FF) begin
                gap <= gap + 10'h001;
            end
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    sequence s_read_of(logic [7:0] a);
        rd_q && addr_q == a;
    endsequence
    sequence s_stall;
        mem_valid_out && !mem_ready_in;
    endsequence
    a_pre_clamp: assert property (s_read_of(8'h08) |-> rdata_out <= `DTS_PRE_MAX)
        else $error("pre-trigger count above limit");
    a_timer_range: assert property (s_read_of(8'h04) |->
        rdata_out >= `DTS_TIMER_MIN_US && rdata_out <= `DTS_TIMER_MAX_US)
        else $error("sample interval out of range");
    a_count_range: assert property (s_read_of(8'h0C) |->
        rdata_out >= `DTS_COUNT_MIN && rdata_out <= `DTS_COUNT_MAX)
        else $error("sample count out of range");
    a_strobe_gap: assert property (sample_strobe_out && seen |-> gap >= 10'd799)
        else $error("samples closer than minimum interval");
    a_mem_hold: assert property (s_stall |=> mem_valid_out && $stable(mem_data_out))
        else $error("memory word dropped while stalled");
    a_start_busy: assert property (start_key_in && !busy_out |=> busy_out)
        else $error("start from idle not taken");
    a_strobe_busy: assert property (sample_strobe_out |-> busy_out)
        else $error("sample taken while idle");
    a_status_busy: assert property (s_read_of(8'h18) |->
        rdata_out[6] == $past(busy_out) && rdata_out[0] == !$past(busy_out))
        else $error("status busy disagrees with busy output");
    a_state_onehot: assert property (s_read_of(8'h18) |-> $onehot(rdata_out[5:0]))
        else $error("status state not one-hot");
endmodule

// file: tb/dts_trig_src.sv
`timescale 1ns/1ps
module dts_trig_src (
    input wire clk_in,
    output reg start_key_out,
    output reg ext_trig_out
);
    initial begin
        start_key_out = 1'b0;
        ext_trig_out = 1'b0;
    end
    // one-cycle key press, as the front panel delivers it
    task press;
        begin
            @(posedge clk_in);
            start_key_out <= 1'b1;
            @(posedge clk_in);
            start_key_out <= 1'b0;
        end
    endtask
    // ttl line is always driven, so a level simply stands until changed
    task drive_ext(input v);
        begin
            @(posedge clk_in);
            ext_trig_out <= v;
        end
    endtask
endmodule

// file: tb/tb_dts_seq.sv
`timescale 1ns/1ps
module tb_dts_seq;
    reg clk_in = 1'b0;
    reg rstn_in = 1'b0;
    reg [7:0] addr_in = 8'h00;
    reg [31:0] wdata_in = 32'h0;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg mem_ready_in = 1'b1;
    reg [23:0] adc_data_in = 24'h0;
    wire [31:0] rdata_out;
    wire start_key, ext_trig, sample_strobe_out, mem_valid_out, busy_out;
    wire [23:0] mem_data_out;
    reg [23:0] got [$];
    integer errors = 0;
    integer total_checks = 0;
    integer cyc = 0;
    integer t0, p, k, t;
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    dts_seq #(.HOLD_AW(6)) dts_seq_inst(.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .start_key_in(start_key), .ext_trig_in(ext_trig), .adc_data_in(adc_data_in),
        .sample_strobe_out(sample_strobe_out), .mem_data_out(mem_data_out),
        .mem_valid_out(mem_valid_out), .mem_ready_in(mem_ready_in), .busy_out(busy_out));
    dts_trig_src dts_trig_src_inst(.clk_in(clk_in), .start_key_out(start_key),
        .ext_trig_out(ext_trig));
    // each captured sample differs from the previous by one, so order and loss show
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (sample_strobe_out === 1'b1) adc_data_in <= adc_data_in + 24'h1;
        if (mem_valid_out === 1'b1 && mem_ready_in) got.push_back(mem_data_out);
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk_in);
            wr_in <= 1'b1;
            addr_in <= a;
            wdata_in <= v;
            @(posedge clk_in);
            wr_in <= 1'b0;
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk_in);
            rd_in <= 1'b1;
            addr_in <= a;
            @(posedge clk_in);
            rd_in <= 1'b0;
            @(posedge clk_in);
            check(rdata_out, exp);
        end
    endtask
    task wait_adc(input integer v);
        integer j;
        begin
            for (j = 0; j < 20000 && adc_data_in < v; j++) @(posedge clk_in);
            if (adc_data_in < v) begin
                errors = errors + 1;
                stop_test;
            end
        end
    endtask
    task wait_idle;
        integer j;
        begin
            @(posedge clk_in);
            for (j = 0; j < 20000 && busy_out !== 1'b0; j++) @(posedge clk_in);
            // busy falls once the last word is queued, so let it reach reading memory
            repeat (4) @(posedge clk_in);
            if (busy_out !== 1'b0) begin
                errors = errors + 1;
                stop_test;
            end
        end
    endtask
    task stream(input integer n);
        integer j;
        begin
            check(got.size(), n);
            for (j = 0; j < n; j++) check(got[j], adc_data_in - n + j);
            got.delete();
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        rdchk(8'h00, 32'h0);
        rdchk(8'h04, 32'h14);
        rdchk(8'h08, 32'h0);
        rdchk(8'h0C, 32'h1);
        rdchk(8'h10, 32'h0);
        rdchk(8'h40, 32'h0);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h14);
        wr(8'h04, 32'hFFFFFFFF);
        rdchk(8'h04, 32'hD693A400);
        wr(8'h04, 32'h14);
        wr(8'h00, 32'h2);
        wr(8'h0C, 32'hFFFFFFFF);
        rdchk(8'h0C, 32'h03000000);
        wr(8'h08, 32'hFFFFFFFF);
        rdchk(8'h08, 32'h000F423F);
        rdchk(8'h0C, 32'h000F4240);
        wr(8'h0C, 32'h0);
        rdchk(8'h0C, 32'h1);
        rdchk(8'h08, 32'h0);
        wr(8'h0C, 32'h5);
        rdchk(8'h08, 32'h4);
        wr(8'h20, 32'h5);
        rdchk(8'h04, 32'h14);
        rdchk(8'h0C, 32'h5);
        rdchk(8'h20, 32'h5);
        wr(8'h10, 32'h32);
        rdchk(8'h10, 32'h0);
        wr(8'h00, 32'h0);
        rdchk(8'h10, 32'h0);
        wr(8'h0C, 32'h2);
        t0 = cyc;
        wr(8'h14, 32'h1);
        wait_adc(adc_data_in + 1);
        check(cyc - t0 < 1000, 32'h1);
        wait_idle;
        stream(2);
        rdchk(8'h18, 32'h081);
        rdchk(8'h1C, 32'h2);
        $display("test immediate done");
        wr(8'h00, 32'h1);
        wr(8'h0C, 32'h1);
        rdchk(8'h10, 32'h32);
        k = adc_data_in;
        dts_trig_src_inst.press();
        repeat (900) @(posedge clk_in);
        rdchk(8'h18, 32'h242);
        check(adc_data_in, k);
        t0 = cyc;
        dts_trig_src_inst.press();
        wait_adc(k + 1);
        check(cyc - t0 >= 2800, 32'h1);
        wait_idle;
        stream(1);
        k = adc_data_in;
        dts_trig_src_inst.press();
        // abort and start in one write: abort wins and nothing is digitized
        wr(8'h14, 32'h3);
        rdchk(8'h18, 32'h201);
        check(adc_data_in, k);
        $display("test manual done");
        wr(8'h08, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h0C, 32'h2);
        for (p = 0; p < 2; p++) begin
            wr(8'h00, p ? 32'h6 : 32'h2);
            dts_trig_src_inst.drive_ext(~p[0]);
            wr(8'h14, 32'h1);
            // the wrong edge for this polarity must leave it waiting
            dts_trig_src_inst.drive_ext(p[0]);
            repeat (50) @(posedge clk_in);
            rdchk(8'h18, 32'h044);
            dts_trig_src_inst.drive_ext(~p[0]);
            wait_idle;
            stream(2);
            $display("test external polarity %0d done", p);
        end
        wr(8'h00, 32'h2);
        wr(8'h0C, 32'h5);
        wr(8'h08, 32'h3);
        wr(8'h10, 32'h32);
        for (k = 5; k > 0; k = k - 4) begin
            mem_ready_in <= 1'b0;
            t = adc_data_in;
            wr(8'h14, 32'h1);
            rdchk(8'h18, 32'h044);
            wait_adc(t + k);
            dts_trig_src_inst.drive_ext(1'b1);
            repeat (20) @(posedge clk_in);
            mem_ready_in <= 1'b1;
            wait_idle;
            stream(k >= 3 ? 5 : k + 2);
            dts_trig_src_inst.drive_ext(1'b0);
            $display("test pre-trigger after %0d samples done", k);
        end
        stop_test;
    end
endmodule
bind dts_seq dts_seq_chk #(.DW(DW)) dts_seq_chk_inst(.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .rd_in(rd_in), .rdata_out(rdata_out), .start_key_in(start_key_in),
    .sample_strobe_out(sample_strobe_out), .mem_data_out(mem_data_out),
    .mem_valid_out(mem_valid_out), .mem_ready_in(mem_ready_in), .busy_out(busy_out));
